// >>> design/extended_test_mode_controller.sv
// Extended test mode: strap sampling, command decoder and LED error codes
`timescale 1ns/1ps
`include "etm_regs.svh"
module extended_test_mode_controller #(
  parameter logic signed [15:0] GND_MIN = 16'sh0000,
  parameter logic signed [15:0] GND_MAX = 16'sh0010
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] service_switch_bank,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic check_valid,
  input wire etm_pkg::check_e check_kind,
  input wire logic signed [15:0] check_mv,
  input wire logic [7:0] check_aux,
  input wire logic check_flag,
  output logic extended_mode,
  output logic [3:0] diagnostic_led_bank,
  output logic [7:0] zero_dac_a,
  output logic [7:0] zero_dac_b,
  output logic [7:0] gain_dac_a,
  output logic [7:0] gain_dac_b,
  output logic [7:0] offset_dac_a,
  output logic [7:0] offset_dac_b,
  output logic [3:0] var_gain_a,
  output logic [3:0] var_gain_b
);

  logic strap_done;
  etm_pkg::parse_e parse;
  etm_pkg::target_e target;
  logic chan;
  logic [9:0] value;
  logic have_digit;
  logic [7:0] zero_dac [2];
  logic [7:0] gain_dac [2];
  logic [7:0] offset_dac [2];
  logic [3:0] var_gain [2];
  logic ref_on_power;
  logic is_digit;
  logic [13:0] next_value;
  logic finish;
  logic in_range;
  logic [3:0] next_code;

  //////////////////////////////////////////////////////////////////////////////
  // Strap sampling

  // Switches are read once after reset release; a later change has no effect
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done <= 1'b0;
      extended_mode <= 1'b0;
    end else if (clk_en && !strap_done) begin
      strap_done <= 1'b1;
      extended_mode <= (service_switch_bank == `ETM_MODE_STRAP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decoder

  // Decimal accumulator saturates so a long number still reads as out of range
  always_comb begin
    is_digit = (rx_byte >= `ETM_CH_0) && (rx_byte <= `ETM_CH_9);
    next_value = {1'b0, value, 3'b000} + {3'b000, value, 1'b0} + {6'h00, rx_byte - `ETM_CH_0};
    if (next_value > `ETM_NUM_SAT) begin
      next_value = `ETM_NUM_SAT;
    end
    finish = clk_en && rx_valid && (parse == etm_pkg::P_NUMBER) && !is_digit;
    if (target == etm_pkg::TGT_VGAIN) begin
      in_range = have_digit && (value <= `ETM_VG_MAX);
    end else begin
      in_range = have_digit && (value <= `ETM_DAC_MAX);
    end
  end

  // Any byte that breaks the pattern drops back to idle; the first non-digit
  // after the number (start of the terminator) closes the command
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      parse <= etm_pkg::P_IDLE;
      target <= etm_pkg::TGT_ZERO;
      chan <= 1'b0;
      value <= 10'h000;
      have_digit <= 1'b0;
    end else if (clk_en && rx_valid && extended_mode) begin
      unique case (parse)
        etm_pkg::P_IDLE: begin
          value <= 10'h000;
          have_digit <= 1'b0;
          parse <= etm_pkg::P_LETTER2;
          unique case (rx_byte)
            `ETM_CH_Z: target <= etm_pkg::TGT_ZERO;
            `ETM_CH_G: target <= etm_pkg::TGT_GAIN;
            `ETM_CH_O: target <= etm_pkg::TGT_OFFSET;
            `ETM_CH_V: target <= etm_pkg::TGT_VGAIN;
            default: parse <= etm_pkg::P_IDLE;
          endcase
        end
        etm_pkg::P_LETTER2: begin
          if (target == etm_pkg::TGT_VGAIN) begin
            parse <= (rx_byte == `ETM_CH_G) ? etm_pkg::P_CHAN : etm_pkg::P_IDLE;
          end else begin
            parse <= (rx_byte == `ETM_CH_D) ? etm_pkg::P_CHAN : etm_pkg::P_IDLE;
          end
        end
        etm_pkg::P_CHAN: begin
          chan <= (rx_byte == `ETM_CH_B);
          if (rx_byte == `ETM_CH_A || rx_byte == `ETM_CH_B) begin
            parse <= etm_pkg::P_NUMBER;
          end else begin
            parse <= etm_pkg::P_IDLE;
          end
        end
        etm_pkg::P_NUMBER: begin
          if (is_digit) begin
            value <= next_value[9:0];
            have_digit <= 1'b1;
          end else begin
            parse <= etm_pkg::P_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Setting storage

  // Each channel setting is written only on a completed in-range command
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_dac <= '{8'h00, 8'h00};
      gain_dac <= '{8'h00, 8'h00};
      offset_dac <= '{8'h00, 8'h00};
      var_gain <= '{4'h0, 4'h0};
    end else if (finish && in_range && extended_mode) begin
      unique case (target)
        etm_pkg::TGT_ZERO: zero_dac[chan] <= value[7:0];
        etm_pkg::TGT_GAIN: gain_dac[chan] <= value[7:0];
        etm_pkg::TGT_OFFSET: offset_dac[chan] <= value[7:0];
        etm_pkg::TGT_VGAIN: var_gain[chan] <= value[3:0];
      endcase
    end
  end

  assign zero_dac_a = zero_dac[0];
  assign zero_dac_b = zero_dac[1];
  assign gain_dac_a = gain_dac[0];
  assign gain_dac_b = gain_dac[1];
  assign offset_dac_a = offset_dac[0];
  assign offset_dac_b = offset_dac[1];
  assign var_gain_a = var_gain[0];
  assign var_gain_b = var_gain[1];

  //////////////////////////////////////////////////////////////////////////////
  // Error code evaluation

  // A passing check keeps the previous code so the last failure stays visible
  always_comb begin
    next_code = diagnostic_led_bank;
    unique case (check_kind)
      etm_pkg::CHK_SENSOR: if (check_flag) next_code = `ETM_LED_NO_SENSOR;
      etm_pkg::CHK_ZERO_LIMIT: begin
        if (check_aux == `ETM_DAC_TOP && check_mv > `ETM_ZERO_MV) begin
          next_code = `ETM_LED_ZERO_HIGH;
        end else if (check_aux == `ETM_DAC_BOT && check_mv < `ETM_ZERO_MV_NEG) begin
          next_code = `ETM_LED_ZERO_LOW;
        end
      end
      etm_pkg::CHK_RANGE: begin
        if (check_mv > `ETM_ZERO_MV || check_mv < `ETM_ZERO_MV_NEG) begin
          if (check_aux == `ETM_RANGE_1) next_code = `ETM_LED_RANGE1;
          if (check_aux == `ETM_RANGE_2) next_code = `ETM_LED_RANGE2;
          if (check_aux == `ETM_RANGE_5) next_code = `ETM_LED_RANGE5;
        end
      end
      etm_pkg::CHK_OFS_64: begin
        if (check_mv < 16'sh0000 || check_mv > `ETM_OFS_MAX_MV) begin
          next_code = `ETM_LED_OFS_VOLT;
        end
      end
      etm_pkg::CHK_OFS_192: if (check_mv >= 16'sh0000) next_code = `ETM_LED_OFS_VOLT;
      etm_pkg::CHK_OFS_CALC: begin
        if (check_mv < 16'sh0000 || check_mv > `ETM_SET_MAX_S) begin
          next_code = `ETM_LED_OFS_SET;
        end
      end
      etm_pkg::CHK_VGAIN: if (check_flag) next_code = `ETM_LED_VGAIN;
      etm_pkg::CHK_ADC_OVF: if (check_flag) next_code = `ETM_LED_ADC_OVF;
      etm_pkg::CHK_GROUND: begin
        if (check_mv < GND_MIN || check_mv > GND_MAX) next_code = `ETM_LED_GROUND;
      end
      etm_pkg::CHK_GAIN_DAC: if (check_flag) next_code = `ETM_LED_GAIN_DAC;
      etm_pkg::CHK_REF_ON: next_code = diagnostic_led_bank;
      etm_pkg::CHK_REF_OFF: begin
        if (check_flag && ref_on_power) next_code = `ETM_LED_ALWAYS_PWR;
      end
      default: next_code = diagnostic_led_bank;
    endcase
  end

  // Power seen with the oscillator on is held until the next oscillator-on test
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_on_power <= 1'b0;
    end else if (clk_en && check_valid && check_kind == etm_pkg::CHK_REF_ON) begin
      ref_on_power <= check_flag;
    end
  end

  // LEDs stay dark outside test mode so normal operation shows nothing
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      diagnostic_led_bank <= `ETM_LED_NONE;
    end else if (clk_en && check_valid && extended_mode) begin
      diagnostic_led_bank <= next_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_mode_strap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!strap_done && clk_en) |=> strap_done &&
      (extended_mode == ($past(service_switch_bank) == `ETM_MODE_STRAP)))
    else $error("mode strap sampled wrongly");

  a_led_dark_normal: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (strap_done && !extended_mode) |-> diagnostic_led_bank == `ETM_LED_NONE)
    else $error("LED code shown outside test mode");

  a_led_no_sensor: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && check_valid && extended_mode && check_kind == etm_pkg::CHK_SENSOR &&
      check_flag) |=> diagnostic_led_bank == `ETM_LED_NO_SENSOR)
    else $error("no sensor code missing");

  a_led_zero_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && check_valid && extended_mode && check_kind == etm_pkg::CHK_ZERO_LIMIT &&
      check_aux == `ETM_DAC_TOP && check_mv > `ETM_ZERO_MV)
      |=> diagnostic_led_bank == `ETM_LED_ZERO_HIGH)
    else $error("zero high code missing");

  a_led_range5: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && check_valid && extended_mode && check_kind == etm_pkg::CHK_RANGE &&
      check_aux == `ETM_RANGE_5 && check_mv < `ETM_ZERO_MV_NEG)
      |=> diagnostic_led_bank == `ETM_LED_RANGE5)
    else $error("range 5 code missing");

  a_zero_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (finish && in_range && target == etm_pkg::TGT_ZERO && !chan)
      |=> zero_dac_a == $past(value[7:0]) && $stable(zero_dac_b))
    else $error("zero DAC A not loaded");

  a_vgain_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (finish && in_range && target == etm_pkg::TGT_VGAIN && chan)
      |=> var_gain_b == $past(value[3:0]) && $stable(var_gain_a))
    else $error("variable gain B not loaded");

  a_range_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (finish && !in_range) |=> $stable(gain_dac_a) && $stable(offset_dac_b) &&
      $stable(zero_dac_a) && $stable(var_gain_a))
    else $error("out of range value was stored");

  a_normal_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (strap_done && !extended_mode) |=> parse == etm_pkg::P_IDLE && $stable(gain_dac_b))
    else $error("command taken outside test mode");

  a_led_zero_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && check_valid && extended_mode && check_kind == etm_pkg::CHK_ZERO_LIMIT &&
      check_aux == `ETM_DAC_BOT && check_mv < `ETM_ZERO_MV_NEG)
      |=> diagnostic_led_bank == `ETM_LED_ZERO_LOW)
    else $error("zero low code missing");

  // Offset at the upper DAC point must come out negative, zero included as a fault
  a_ofs_positive: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && check_valid && extended_mode && check_kind == etm_pkg::CHK_OFS_192 &&
      check_mv >= 16'sh0000)
      |=> diagnostic_led_bank == `ETM_LED_OFS_VOLT)
    else $error("offset at upper point code missing");

  a_ofs_setting: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && check_valid && extended_mode && check_kind == etm_pkg::CHK_OFS_CALC &&
      check_mv > `ETM_SET_MAX_S)
      |=> diagnostic_led_bank == `ETM_LED_OFS_SET)
    else $error("offset setting code missing");

  a_ref_always: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && check_valid && extended_mode && check_kind == etm_pkg::CHK_REF_OFF &&
      check_flag && ref_on_power) |=> diagnostic_led_bank == `ETM_LED_ALWAYS_PWR)
    else $error("always power code missing");

  // A low enable must hold display, settings and mode exactly as they were
  a_clk_frozen: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !clk_en |=> $stable(diagnostic_led_bank) && $stable(zero_dac_b) &&
      $stable(gain_dac_a) && $stable(extended_mode))
    else $error("state moved while clock enable low");

  c_zero_cmd: cover property (@(posedge sys_clk) disable iff (sys_rst)
    finish && in_range && target == etm_pkg::TGT_ZERO);
  c_reject_cmd: cover property (@(posedge sys_clk) disable iff (sys_rst)
    finish && !in_range);
  c_always_power: cover property (@(posedge sys_clk) disable iff (sys_rst)
    diagnostic_led_bank == `ETM_LED_ALWAYS_PWR);
  c_vgain_cmd: cover property (@(posedge sys_clk) disable iff (sys_rst)
    finish && in_range && target == etm_pkg::TGT_VGAIN);
  c_frozen_byte: cover property (@(posedge sys_clk) disable iff (sys_rst)
    !clk_en && rx_valid && extended_mode);

endmodule

// >>> pkg/etm_regs.svh
// Constants of the extended test mode controller
// Overview of operation
// - Enter test mode when switches read 14
// - Show error codes on LED bank in test
// - Code 0001 when no sensor found
// - Code 0010: zero DAC at 255, input high
// - Code 0011: zero DAC at 0, input low
// - Codes 0100/0101/0110 for ranges 1,2,5 off
// - Code 0111 for bad offset at 64/192
// - Code 1000 for offset setting out of range
// - Code 1001 when no gain gives cal voltage
// - Code 1010 on converter overflow in adjust
// - Code 1011 for ground count out of range
// - Code 1100 when no gain DAC gives 1 V
// - Code 1101 when power seen both oscillator states
// - Zero DAC command loads 0..255 per channel
// - Gain DAC command loads 0..255 per channel
// - Offset DAC command loads 0..255 per channel
// - Variable gain command loads 0..15 per channel
// - Setting commands work only in test mode
`ifndef ETM_REGS_SVH
`define ETM_REGS_SVH
`define ETM_MODE_STRAP 4'he
`define ETM_DAC_MAX 10'h0ff
`define ETM_VG_MAX 10'h00f
`define ETM_NUM_SAT 14'h03e7
`define ETM_DAC_TOP 8'hff
`define ETM_DAC_BOT 8'h00
`define ETM_ZERO_MV 16'sh008c
`define ETM_ZERO_MV_NEG -16'sh008c
`define ETM_OFS_MAX_MV 16'sh02ee
`define ETM_SET_MAX_S 16'sh00ff
`define ETM_RANGE_1 8'h01
`define ETM_RANGE_2 8'h02
`define ETM_RANGE_5 8'h05
`define ETM_CH_Z 8'h5a
`define ETM_CH_G 8'h47
`define ETM_CH_O 8'h4f
`define ETM_CH_V 8'h56
`define ETM_CH_D 8'h44
`define ETM_CH_A 8'h41
`define ETM_CH_B 8'h42
`define ETM_CH_0 8'h30
`define ETM_CH_9 8'h39
`define ETM_LED_NONE 4'h0
`define ETM_LED_NO_SENSOR 4'h1
`define ETM_LED_ZERO_HIGH 4'h2
`define ETM_LED_ZERO_LOW 4'h3
`define ETM_LED_RANGE1 4'h4
`define ETM_LED_RANGE2 4'h5
`define ETM_LED_RANGE5 4'h6
`define ETM_LED_OFS_VOLT 4'h7
`define ETM_LED_OFS_SET 4'h8
`define ETM_LED_VGAIN 4'h9
`define ETM_LED_ADC_OVF 4'ha
`define ETM_LED_GROUND 4'hb
`define ETM_LED_GAIN_DAC 4'hc
`define ETM_LED_ALWAYS_PWR 4'hd
`endif

// >>> pkg/etm_pkg.sv
// Types shared by the extended test mode controller
package etm_pkg;
  typedef enum logic [1:0] {TGT_ZERO, TGT_GAIN, TGT_OFFSET, TGT_VGAIN} target_e;
  typedef enum logic [1:0] {P_IDLE, P_LETTER2, P_CHAN, P_NUMBER} parse_e;
  typedef enum logic [3:0] {
    CHK_SENSOR, CHK_ZERO_LIMIT, CHK_RANGE, CHK_OFS_64, CHK_OFS_192, CHK_OFS_CALC,
    CHK_VGAIN, CHK_ADC_OVF, CHK_GROUND, CHK_GAIN_DAC, CHK_REF_ON, CHK_REF_OFF
  } check_e;
endpackage

// >>> testbench/bus_host_model.sv
// Bus controller model: sends setting commands as unbroken byte strings
`timescale 1ns/1ps
`include "etm_regs.svh"
module bus_host_model (
  input wire logic sys_clk,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // One byte per falling edge, back to back, so no filler can creep in
  task automatic put_byte(input logic [7:0] b);
    @(negedge sys_clk);
    rx_valid = 1'b1;
    rx_byte = b;
  endtask
  // Command, channel, decimal value most significant digit first, terminator
  task automatic send_setting(input logic [7:0] l1, input logic [7:0] l2,
                              input logic [7:0] ch, input int value);
    put_byte(l1);
    put_byte(l2);
    put_byte(ch);
    if (value >= 100) put_byte(`ETM_CH_0 + 8'(value / 100));
    if (value >= 10) put_byte(`ETM_CH_0 + 8'((value / 10) % 10));
    put_byte(`ETM_CH_0 + 8'(value % 10));
    put_byte(8'h45);
    put_byte(8'h4e);
    @(negedge sys_clk);
    rx_valid = 1'b0;
    // Idle bus shows the inverse of the last byte, never a stale copy
    rx_byte = ~8'h4e;
  endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the extended test mode controller
`timescale 1ns/1ps
`include "etm_regs.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] service_switch_bank = 4'h0;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic check_valid = 1'b0;
  etm_pkg::check_e check_kind = etm_pkg::CHK_SENSOR;
  logic signed [15:0] check_mv = 16'sh0000;
  logic [7:0] check_aux = 8'h00;
  logic check_flag = 1'b0;
  logic extended_mode;
  logic [3:0] diagnostic_led_bank;
  logic [7:0] zero_dac_a, zero_dac_b, gain_dac_a, gain_dac_b, offset_dac_a, offset_dac_b;
  logic [3:0] var_gain_a, var_gain_b;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;
  extended_test_mode_controller extended_test_mode_controller_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .service_switch_bank(service_switch_bank), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .check_valid(check_valid), .check_kind(check_kind), .check_mv(check_mv),
    .check_aux(check_aux), .check_flag(check_flag), .extended_mode(extended_mode),
    .diagnostic_led_bank(diagnostic_led_bank), .zero_dac_a(zero_dac_a),
    .zero_dac_b(zero_dac_b), .gain_dac_a(gain_dac_a), .gain_dac_b(gain_dac_b),
    .offset_dac_a(offset_dac_a), .offset_dac_b(offset_dac_b),
    .var_gain_a(var_gain_a), .var_gain_b(var_gain_b));
  bus_host_model bus_host_model_inst (
    .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Well above the roughly 190 cycles the scenarios need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reset for 12 cycles with the strap set, then let the strap be sampled
  task automatic apply_reset(input logic [3:0] sw);
    sys_rst = 1'b1;
    service_switch_bank = sw;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic run_check(input etm_pkg::check_e k, input logic signed [15:0] mv,
                           input logic [7:0] aux, input logic flag, input logic [3:0] exp);
    @(negedge sys_clk);
    check_valid = 1'b1;
    check_kind = k;
    check_mv = mv;
    check_aux = aux;
    check_flag = flag;
    @(negedge sys_clk);
    check_valid = 1'b0;
    compare(16'(diagnostic_led_bank), 16'(exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Strap of 13 must lock out both bus commands and the LED display
  task automatic t_locked();
    apply_reset(4'hd);
    compare(16'(extended_mode), 16'h0000);
    bus_host_model_inst.send_setting(`ETM_CH_Z, `ETM_CH_D, `ETM_CH_A, 77);
    compare(16'(zero_dac_a), 16'h0000);
    run_check(etm_pkg::CHK_SENSOR, 16'sh0000, 8'h00, 1'b1, 4'h0);
  endtask
  // Every command on both channels, upper range ends of zero and variable gain included
  task automatic t_commands();
    apply_reset(`ETM_MODE_STRAP);
    compare(16'(extended_mode), 16'h0001);
    bus_host_model_inst.send_setting(`ETM_CH_Z, `ETM_CH_D, `ETM_CH_A, 255);
    bus_host_model_inst.send_setting(`ETM_CH_Z, `ETM_CH_D, `ETM_CH_B, 9);
    bus_host_model_inst.send_setting(`ETM_CH_G, `ETM_CH_D, `ETM_CH_A, 128);
    bus_host_model_inst.send_setting(`ETM_CH_G, `ETM_CH_D, `ETM_CH_B, 1);
    bus_host_model_inst.send_setting(`ETM_CH_O, `ETM_CH_D, `ETM_CH_A, 64);
    bus_host_model_inst.send_setting(`ETM_CH_O, `ETM_CH_D, `ETM_CH_B, 192);
    bus_host_model_inst.send_setting(`ETM_CH_V, `ETM_CH_G, `ETM_CH_A, 15);
    bus_host_model_inst.send_setting(`ETM_CH_V, `ETM_CH_G, `ETM_CH_B, 5);
    compare({zero_dac_a, zero_dac_b}, 16'hff09);
    compare({gain_dac_a, gain_dac_b}, 16'h8001);
    compare({offset_dac_a, offset_dac_b}, 16'h40c0);
    compare({var_gain_a, var_gain_b}, 16'h00f5);
  endtask
  // Values past the limit must leave the old setting in place
  task automatic t_out_of_range();
    bus_host_model_inst.send_setting(`ETM_CH_Z, `ETM_CH_D, `ETM_CH_A, 256);
    bus_host_model_inst.send_setting(`ETM_CH_V, `ETM_CH_G, `ETM_CH_B, 16);
    bus_host_model_inst.send_setting(`ETM_CH_G, `ETM_CH_D, `ETM_CH_A, 999);
    compare({zero_dac_a, gain_dac_a}, 16'hff80);
    compare(16'(var_gain_b), 16'h0005);
  endtask
  // Each failing check shows its code; passes at the limits keep the old one
  task automatic t_codes();
    run_check(etm_pkg::CHK_SENSOR, 16'sh0000, 8'h00, 1'b1, 4'h1);
    run_check(etm_pkg::CHK_ZERO_LIMIT, 16'sh00c8, 8'hff, 1'b0, 4'h2);
    run_check(etm_pkg::CHK_ZERO_LIMIT, -16'sh00c8, 8'h00, 1'b0, 4'h3);
    run_check(etm_pkg::CHK_RANGE, 16'sh008d, 8'h01, 1'b0, 4'h4);
    run_check(etm_pkg::CHK_RANGE, -16'sh008d, 8'h02, 1'b0, 4'h5);
    run_check(etm_pkg::CHK_RANGE, 16'sh008d, 8'h05, 1'b0, 4'h6);
    run_check(etm_pkg::CHK_RANGE, 16'sh008c, 8'h01, 1'b0, 4'h6);
    run_check(etm_pkg::CHK_OFS_64, 16'sh02ef, 8'h00, 1'b0, 4'h7);
    run_check(etm_pkg::CHK_OFS_CALC, 16'sh0100, 8'h00, 1'b0, 4'h8);
    run_check(etm_pkg::CHK_OFS_192, 16'sh0000, 8'h00, 1'b0, 4'h7);
    run_check(etm_pkg::CHK_OFS_CALC, -16'sh0001, 8'h00, 1'b0, 4'h8);
    run_check(etm_pkg::CHK_OFS_64, 16'sh02ee, 8'h00, 1'b0, 4'h8);
    run_check(etm_pkg::CHK_VGAIN, 16'sh0000, 8'h00, 1'b1, 4'h9);
    run_check(etm_pkg::CHK_ADC_OVF, 16'sh0000, 8'h00, 1'b1, 4'ha);
    run_check(etm_pkg::CHK_GROUND, 16'sh0011, 8'h00, 1'b0, 4'hb);
    run_check(etm_pkg::CHK_GAIN_DAC, 16'sh0000, 8'h00, 1'b1, 4'hc);
    run_check(etm_pkg::CHK_REF_ON, 16'sh0000, 8'h00, 1'b1, 4'hc);
    run_check(etm_pkg::CHK_REF_OFF, 16'sh0000, 8'h00, 1'b1, 4'hd);
  endtask
  // Clock enable low must freeze decoder and display alike
  task automatic t_frozen();
    @(negedge sys_clk);
    clk_en = 1'b0;
    bus_host_model_inst.send_setting(`ETM_CH_Z, `ETM_CH_D, `ETM_CH_B, 77);
    run_check(etm_pkg::CHK_SENSOR, 16'sh0000, 8'h00, 1'b1, 4'hd);
    clk_en = 1'b1;
    compare(16'(zero_dac_b), 16'h0009);
  endtask
  // A second reset in mid-run clears display and settings
  task automatic t_rereset();
    apply_reset(`ETM_MODE_STRAP);
    compare({4'h0, diagnostic_led_bank, zero_dac_a}, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_locked();
    t_commands();
    t_out_of_range();
    t_codes();
    t_frozen();
    t_rereset();
    close_out();
  end
endmodule
